// ==== hdl/modem_pkg.sv ====
/*
  Constants, register map and carrier types for the dual-port modem
  handshake block.
  Assumes a single 10 MHz clock domain and an 8-bit register port.
*/
package modem_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int PORT_N = 2;
  localparam int LINE_N = 4;
  localparam int CLK_PERIOD_NS = 100;

  // ----------------------------------------------------------------
  // Register offsets (per-port block of four, then shared registers)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] PORT_STRIDE = 4'h4;
  localparam logic [ADDR_W-1:0] CTL_OFF = 4'h0;
  localparam logic [ADDR_W-1:0] IER_OFF = 4'h1;
  localparam logic [ADDR_W-1:0] STS_OFF = 4'h2;
  localparam logic [ADDR_W-1:0] IR_CTRL_OFF = 4'h8;
  localparam logic [ADDR_W-1:0] INT_STAT_OFF = 4'h9;
  localparam logic [ADDR_W-1:0] INT_MASK_OFF = 4'hA;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTL_DTR_BIT = 0;
  localparam int CTL_RTS_BIT = 1;
  localparam int CTL_LOOP_BIT = 4;
  localparam int IER_MODEM_BIT = 3;
  localparam int IR_SEL_BIT = 0;
  localparam int STS_DELTA_LSB = 0;
  localparam int STS_LEVEL_LSB = 4;

  // ----------------------------------------------------------------
  // Reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] CTL_RST = 8'h00;
  localparam logic [DATA_W-1:0] IER_RST = 8'h00;
  localparam logic [DATA_W-1:0] IR_CTRL_RST = 8'h00;
  localparam logic [DATA_W-1:0] INT_MASK_RST = 8'h00;
  localparam logic [DATA_W-1:0] CTL_WMASK = 8'h13;
  localparam logic [DATA_W-1:0] IER_WMASK = 8'h08;
  localparam logic [DATA_W-1:0] IR_CTRL_WMASK = 8'h01;
  localparam logic [DATA_W-1:0] INT_WMASK = 8'h03;
  localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
  localparam logic [LINE_N-1:0] LINE_IDLE = 4'hF;
  localparam logic [LINE_N-1:0] DELTA_NONE = 4'h0;
  localparam logic [PORT_N*LINE_N-1:0] SYNC_IDLE = 8'hFF;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  // Member order matches the status bits: cts lowest, dcd highest
  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
  } modem_in_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

endpackage

// ==== hdl/modem_line_sync.sv ====
/*
  Two-stage synchroniser bank for the modem status input pins.
  Assumes the pins are asynchronous to clk_i and idle high.
*/
`timescale 1ns/1ps
`default_nettype none
module modem_line_sync
  import modem_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Pins and synchronised levels
  input wire logic [PORT_N*LINE_N-1:0] async_i,
  output logic [PORT_N*LINE_N-1:0] sync_o
);

  logic [PORT_N*LINE_N-1:0] meta_reg;

  // First stage feeds only the second
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      meta_reg <= SYNC_IDLE;
      sync_o <= SYNC_IDLE;
    end
    else
    begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end

endmodule
`default_nettype wire

// ==== hdl/serial_pin_select.sv ====
/*
  Output selector for the shared secondary transmit pin.
  Assumes both data streams are produced on clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_pin_select
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Stream selection and data
  input wire logic ir_mode_i,
  input wire logic serial_i,
  input wire logic infrared_i,
  // Pin
  output logic pin_o
);

  // Idle mark level until the first stream bit arrives
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pin_o <= 1'b1;
    end
    else
    begin
      pin_o <= ir_mode_i ? infrared_i : serial_i; // RULE13
    end
  end

endmodule
`default_nettype wire

// ==== hdl/uart_modem_handshake.sv ====
/*
  Modem handshake logic for two serial ports: control outputs, status
  inputs with change flags, per-port and summary interrupts, and the
  shared secondary transmit pin.
  Assumes a CPU register port on clk_i with one-cycle strobes and
  modem pins asynchronous to clk_i.
*/
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// RULE1: request-to-send pin is inverted control bit 1
// RULE2: terminal-ready pin is inverted control bit 0
// RULE3: reset drives both handshake pins high
// RULE4: loopback forces both handshake pins high
// RULE5: status bit 4 is inverted clear-to-send
// RULE6: status bit 5 is inverted set-ready
// RULE7: status bit 7 is inverted carrier
// RULE8: clear-to-send change sets status bit 0
// RULE9: set-ready change sets status bit 1
// RULE10: carrier change sets status bit 3
// RULE11: enable bit 3 raises interrupt on change
// RULE12: clear-to-send never gates the transmitter
// RULE13: secondary pin carries serial or infrared data
// RULE14: status bit 6 inverted ring, bit 2 change
// RULE15: status read clears the four change flags
module uart_modem_handshake
  import modem_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  // Primary modem inputs, active low
  input wire logic primary_clear_to_send_in_n_i,
  input wire logic primary_set_ready_in_n_i,
  input wire logic primary_carrier_in_n_i,
  input wire logic primary_ring_in_n_i,
  // Secondary modem inputs, active low
  input wire logic secondary_clear_to_send_in_n_i,
  input wire logic secondary_set_ready_in_n_i,
  input wire logic secondary_carrier_in_n_i,
  input wire logic secondary_ring_in_n_i,
  // Modem control outputs, active low
  output logic primary_send_request_out_n_o,
  output logic primary_terminal_ready_out_n_o,
  output logic secondary_send_request_out_n_o,
  output logic secondary_terminal_ready_out_n_o,
  // Transmit streams from the framers
  input wire logic secondary_tx_data_i,
  input wire logic infrared_tx_data_i,
  output logic secondary_serial_out_o,
  // Loopback indication to the framers
  output logic primary_loopback_o,
  output logic secondary_loopback_o,
  // Interrupts
  output logic primary_port_irq_o,
  output logic secondary_port_irq_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic [ADDR_W-1:0] port_addr(input int port, input logic [ADDR_W-1:0] off);
    port_addr = off + PORT_STRIDE * port[ADDR_W-1:0];
  endfunction

  function automatic logic wr_hit(input bus_req_t r, input logic [ADDR_W-1:0] a);
    wr_hit = r.wr && (r.addr == a);
  endfunction

  function automatic logic rd_hit(input bus_req_t r, input logic [ADDR_W-1:0] a);
    rd_hit = r.rd && (r.addr == a);
  endfunction

  // Status byte: inverted levels on top, change flags below
  function automatic logic [DATA_W-1:0] status_byte(input modem_in_t lvl, input logic [LINE_N-1:0] delta);
    status_byte = {~lvl, delta}; // RULE5 RULE6 RULE7 RULE14
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  bus_req_t req;
  logic [PORT_N*LINE_N-1:0] pin_vec;
  logic [PORT_N*LINE_N-1:0] sync_vec;
  modem_in_t [PORT_N-1:0] line_q;
  modem_in_t [PORT_N-1:0] prev_reg;
  logic [PORT_N-1:0][LINE_N-1:0] change;
  logic [PORT_N-1:0][LINE_N-1:0] delta_reg;
  logic [PORT_N-1:0][LINE_N-1:0] delta_next;
  logic [PORT_N-1:0][DATA_W-1:0] ctl_reg;
  logic [PORT_N-1:0][DATA_W-1:0] ier_reg;
  logic [PORT_N-1:0] sts_rd;
  logic [PORT_N-1:0] port_irq_next;
  logic [DATA_W-1:0] ir_ctrl_reg;
  logic [DATA_W-1:0] int_stat_reg;
  logic [DATA_W-1:0] int_stat_next;
  logic [DATA_W-1:0] int_mask_reg;
  logic [DATA_W-1:0] int_event;
  logic [DATA_W-1:0] rdata_next;

  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  assign pin_vec = {secondary_carrier_in_n_i, secondary_ring_in_n_i,
                    secondary_set_ready_in_n_i, secondary_clear_to_send_in_n_i,
                    primary_carrier_in_n_i, primary_ring_in_n_i,
                    primary_set_ready_in_n_i, primary_clear_to_send_in_n_i};

  modem_line_sync u_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(pin_vec),
    .sync_o(sync_vec)
  );

  assign line_q = sync_vec;

  // ----------------------------------------------------------------
  // Change detection
  // ----------------------------------------------------------------
  // Either direction counts, so a short glitch pair is still seen
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      for (int p = 0; p < PORT_N; p++)
      begin
        prev_reg[p] <= LINE_IDLE;
      end
    end
    else
    begin
      prev_reg <= line_q;
    end
  end

  always_comb
  begin
    for (int p = 0; p < PORT_N; p++)
    begin
      change[p] = prev_reg[p] ^ line_q[p]; // RULE8 RULE9 RULE10 RULE14
      sts_rd[p] = rd_hit(req, port_addr(p, STS_OFF));
      // A change in the read cycle survives the clear
      delta_next[p] = (sts_rd[p] ? DELTA_NONE : delta_reg[p]) | change[p]; // RULE15
      port_irq_next[p] = ier_reg[p][IER_MODEM_BIT] && (|delta_next[p]); // RULE11
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      for (int p = 0; p < PORT_N; p++)
      begin
        delta_reg[p] <= DELTA_NONE;
      end
    end
    else
    begin
      delta_reg <= delta_next;
    end
  end

  // ----------------------------------------------------------------
  // Per-port control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      for (int p = 0; p < PORT_N; p++)
      begin
        ctl_reg[p] <= CTL_RST;
        ier_reg[p] <= IER_RST;
      end
    end
    else
    begin
      for (int p = 0; p < PORT_N; p++)
      begin
        if (wr_hit(req, port_addr(p, CTL_OFF)))
        begin
          ctl_reg[p] <= req.wdata & CTL_WMASK;
        end
        if (wr_hit(req, port_addr(p, IER_OFF)))
        begin
          ier_reg[p] <= req.wdata & IER_WMASK;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Handshake outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      primary_send_request_out_n_o <= 1'b1; // RULE3
      primary_terminal_ready_out_n_o <= 1'b1; // RULE3
      secondary_send_request_out_n_o <= 1'b1; // RULE3
      secondary_terminal_ready_out_n_o <= 1'b1; // RULE3
    end
    else
    begin
      primary_send_request_out_n_o <= ctl_reg[0][CTL_LOOP_BIT] || !ctl_reg[0][CTL_RTS_BIT]; // RULE1 RULE4
      primary_terminal_ready_out_n_o <= ctl_reg[0][CTL_LOOP_BIT] || !ctl_reg[0][CTL_DTR_BIT]; // RULE2 RULE4
      secondary_send_request_out_n_o <= ctl_reg[1][CTL_LOOP_BIT] || !ctl_reg[1][CTL_RTS_BIT]; // RULE1 RULE4
      secondary_terminal_ready_out_n_o <= ctl_reg[1][CTL_LOOP_BIT] || !ctl_reg[1][CTL_DTR_BIT]; // RULE2 RULE4
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      primary_loopback_o <= 1'b0;
      secondary_loopback_o <= 1'b0;
    end
    else
    begin
      primary_loopback_o <= ctl_reg[0][CTL_LOOP_BIT];
      secondary_loopback_o <= ctl_reg[1][CTL_LOOP_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Secondary transmit pin
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      ir_ctrl_reg <= IR_CTRL_RST;
    end
    else if (wr_hit(req, IR_CTRL_OFF))
    begin
      ir_ctrl_reg <= req.wdata & IR_CTRL_WMASK;
    end
  end

  // Data is registered once and never gated; clear-to-send only feeds status
  serial_pin_select u_txsel (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ir_mode_i(ir_ctrl_reg[IR_SEL_BIT]),
    .serial_i(secondary_tx_data_i), // RULE12
    .infrared_i(infrared_tx_data_i),
    .pin_o(secondary_serial_out_o)
  );

  // ----------------------------------------------------------------
  // Interrupt summary
  // ----------------------------------------------------------------
  always_comb
  begin
    int_event = READ_ZERO;
    for (int p = 0; p < PORT_N; p++)
    begin
      int_event[p] = |change[p];
    end
    // Set wins over the read clear
    int_stat_next = (rd_hit(req, INT_STAT_OFF) ? READ_ZERO : int_stat_reg) | int_event;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      int_stat_reg <= READ_ZERO;
      int_mask_reg <= INT_MASK_RST;
    end
    else
    begin
      int_stat_reg <= int_stat_next;
      if (wr_hit(req, INT_MASK_OFF))
      begin
        int_mask_reg <= req.wdata & INT_WMASK;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      irq_o <= 1'b0;
      primary_port_irq_o <= 1'b0;
      secondary_port_irq_o <= 1'b0;
    end
    else
    begin
      irq_o <= |(int_stat_next & int_mask_reg);
      primary_port_irq_o <= port_irq_next[0]; // RULE11
      secondary_port_irq_o <= port_irq_next[1]; // RULE11
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb
  begin
    rdata_next = READ_ZERO;
    if (req.rd)
    begin
      for (int p = 0; p < PORT_N; p++)
      begin
        if (req.addr == port_addr(p, CTL_OFF))
        begin
          rdata_next = ctl_reg[p];
        end
        if (req.addr == port_addr(p, IER_OFF))
        begin
          rdata_next = ier_reg[p];
        end
        if (req.addr == port_addr(p, STS_OFF))
        begin
          rdata_next = status_byte(line_q[p], delta_reg[p]); // RULE5 RULE6 RULE7
        end
      end
      if (req.addr == IR_CTRL_OFF)
      begin
        rdata_next = ir_ctrl_reg;
      end
      if (req.addr == INT_STAT_OFF)
      begin
        rdata_next = int_stat_reg;
      end
      if (req.addr == INT_MASK_OFF)
      begin
        rdata_next = int_mask_reg;
      end
    end
  end

  // Data stand only in the cycle after the strobe
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rdata_o <= READ_ZERO;
    end
    else
    begin
      rdata_o <= rdata_next;
    end
  end

endmodule
`default_nettype wire

// ==== bench/modem_assertions.sv ====
/*
  Port checker for uart_modem_handshake, bound to the top module.
  Assumes the bench holds the modem pins idle across every reset.
*/
`timescale 1ns/1ps
`default_nettype none
module modem_assertions
  import modem_pkg::*;
(
  // Clock, reset and register port
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [DATA_W-1:0] rdata_o,
  // Modem pins
  input wire logic primary_clear_to_send_in_n_i,
  input wire logic primary_set_ready_in_n_i,
  input wire logic primary_carrier_in_n_i,
  input wire logic primary_ring_in_n_i,
  input wire logic primary_send_request_out_n_o,
  input wire logic primary_terminal_ready_out_n_o,
  input wire logic secondary_send_request_out_n_o,
  input wire logic secondary_terminal_ready_out_n_o,
  // Transmit path and interrupt
  input wire logic secondary_tx_data_i,
  input wire logic infrared_tx_data_i,
  input wire logic secondary_serial_out_o,
  input wire logic primary_port_irq_o
);
  wire [3:0] pins = {primary_carrier_in_n_i, primary_ring_in_n_i, primary_set_ready_in_n_i,
    primary_clear_to_send_in_n_i};
  wire sts_rd = rd_i && addr_i == STS_OFF;
  logic [3:0] p1, quiet;
  logic mw0_1, mw0_2, mw1_1, mw1_2, ier_on, ir_on, ir_on_1, unread;
  logic [7:0] wd1, wd2;
  // Calm: pins settled long enough to have crossed the synchroniser
  wire calm = quiet >= 4'h4;

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      {p1, quiet} <= {LINE_IDLE, 4'hF};
      {mw0_1, mw0_2, mw1_1, mw1_2, ier_on, ir_on, ir_on_1, unread} <= '0;
      {wd1, wd2} <= '0;
    end
    else
    begin
      p1 <= pins;
      quiet <= (pins != p1) ? 4'h0 : quiet + {3'h0, quiet != 4'hF};
      mw0_1 <= wr_i && addr_i == CTL_OFF;
      mw1_1 <= wr_i && addr_i == PORT_STRIDE + CTL_OFF;
      {mw0_2, mw1_2, wd2, wd1} <= {mw0_1, mw1_1, wd1, wdata_i};
      if (wr_i && addr_i == IER_OFF)
        ier_on <= wdata_i[IER_MODEM_BIT];
      if (wr_i && addr_i == IR_CTRL_OFF)
        ir_on <= wdata_i[IR_SEL_BIT];
      ir_on_1 <= ir_on;
      // Only a read of settled flags counts as having seen the change
      if (pins != p1)
        unread <= 1'b1;
      else if (sts_rd && calm)
        unread <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  chk_rts_prim_value: assert property (mw0_2 && !mw0_1 |->
    primary_send_request_out_n_o == !(wd2[CTL_RTS_BIT] && !wd2[CTL_LOOP_BIT])) else $error("primary rts wrong");
  chk_dtr_prim_value: assert property (mw0_2 && !mw0_1 |->
    primary_terminal_ready_out_n_o == !(wd2[CTL_DTR_BIT] && !wd2[CTL_LOOP_BIT])) else $error("primary dtr wrong");
  chk_rts_sec_value: assert property (mw1_2 && !mw1_1 |->
    secondary_send_request_out_n_o == !(wd2[CTL_RTS_BIT] && !wd2[CTL_LOOP_BIT])) else $error("second rts wrong");
  chk_reset_pins_high: assert property (disable iff (1'b0) sys_rst_i |-> &{primary_send_request_out_n_o,
    primary_terminal_ready_out_n_o, secondary_send_request_out_n_o, secondary_terminal_ready_out_n_o})
    else $error("handshake low in reset");
  chk_status_levels: assert property (sts_rd && calm |=>
    rdata_o[7:4] == ~$past(pins)) else $error("status levels wrong");
  chk_change_flagged: assert property (sts_rd && calm && unread |=>
    rdata_o[3:0] != DELTA_NONE) else $error("change not flagged");
  chk_read_clears: assert property (sts_rd && calm && !unread |=>
    rdata_o[3:0] == DELTA_NONE) else $error("stale change flag");
  chk_irq_on_change: assert property (ier_on && $past(ier_on) && unread && calm |->
    primary_port_irq_o) else $error("port irq missing");
  chk_irq_gated_off: assert property (!ier_on && !$past(ier_on) |-> !primary_port_irq_o)
    else $error("port irq while disabled");
  chk_tx_pin_select: assert property (ir_on == ir_on_1 |-> secondary_serial_out_o ==
    (ir_on_1 ? $past(infrared_tx_data_i) : $past(secondary_tx_data_i))) else $error("tx pin wrong");
endmodule

bind uart_modem_handshake modem_assertions chk (.clk_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
  .primary_clear_to_send_in_n_i, .primary_set_ready_in_n_i, .primary_carrier_in_n_i, .primary_ring_in_n_i,
  .primary_send_request_out_n_o, .primary_terminal_ready_out_n_o, .secondary_send_request_out_n_o,
  .secondary_terminal_ready_out_n_o, .secondary_tx_data_i, .infrared_tx_data_i, .secondary_serial_out_o,
  .primary_port_irq_o);
`default_nettype wire

// ==== bench/modem_model.sv ====
/*
  Modem stand-in that drives the status pins of both ports.
  Assumes the bench commands line levels at clock edges.
*/
`timescale 1ns/1ps
`default_nettype none
module modem_model
  import modem_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Commanded levels
  input wire modem_in_t want0_i,
  input wire modem_in_t want1_i,
  // Pins, active low
  output var modem_in_t pin0_o,
  output var modem_in_t pin1_o
);
  // Quarter-period lag keeps pin edges away from the sampling edge
  initial
  begin
    pin0_o = LINE_IDLE;
    pin1_o = LINE_IDLE;
    forever
    begin
      @(posedge clk_i);
      pin0_o <= #(CLK_PERIOD_NS / 4) want0_i;
      pin1_o <= #(CLK_PERIOD_NS / 4) want1_i;
    end
  end
endmodule
`default_nettype wire

// ==== bench/uart_modem_handshake_tb_top.sv ====
/*
  Directed bench for uart_modem_handshake: register calls and pin moves.
  Assumes the checker is bound and the modem model drives the pins.
*/
`timescale 1ns/1ps
`default_nettype none
module uart_modem_handshake_tb_top
  import modem_pkg::*;
;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic tx_s = 1'b1;
  logic tx_ir = 1'b1;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wdata_i = '0;
  logic [DATA_W-1:0] rdata_o;
  logic [3:0] lv, a;
  modem_in_t want0 = LINE_IDLE;
  modem_in_t want1 = LINE_IDLE;
  modem_in_t pin0, pin1;
  logic rts0, dtr0, rts1, dtr1, ser, lb0, lb1, irq0, irq1, irq;
  int fail_count = 0;
  int num_checks = 0;

  always #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;

  modem_model partner (.clk_i(clk_i), .want0_i(want0), .want1_i(want1), .pin0_o(pin0), .pin1_o(pin1));
  uart_modem_handshake uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .primary_clear_to_send_in_n_i(pin0.cts), .primary_set_ready_in_n_i(pin0.dsr),
    .primary_carrier_in_n_i(pin0.dcd), .primary_ring_in_n_i(pin0.ri),
    .secondary_clear_to_send_in_n_i(pin1.cts), .secondary_set_ready_in_n_i(pin1.dsr),
    .secondary_carrier_in_n_i(pin1.dcd), .secondary_ring_in_n_i(pin1.ri),
    .primary_send_request_out_n_o(rts0), .primary_terminal_ready_out_n_o(dtr0),
    .secondary_send_request_out_n_o(rts1), .secondary_terminal_ready_out_n_o(dtr1),
    .secondary_tx_data_i(tx_s), .infrared_tx_data_i(tx_ir), .secondary_serial_out_o(ser),
    .primary_loopback_o(lb0), .secondary_loopback_o(lb1),
    .primary_port_irq_o(irq0), .secondary_port_irq_o(irq1), .irq_o(irq));

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] ad, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= ad;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rc(input logic [3:0] ad, input logic [7:0] exp);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= ad;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 check(rdata_o, exp);
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    // Rising edge at time zero so the asynchronous reset acts at once
    sys_rst_i <= 1'b1;
    step(7);
    check({rts0, dtr0, rts1, dtr1}, 8'h0F);
    @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rc(STS_OFF, 8'h00);
    wr(CTL_OFF, 8'h01);
    step(2);
    check({rts0, dtr0}, 8'h02);
    wr(CTL_OFF, 8'hFF);
    step(2);
    check({rts0, dtr0, lb0}, 8'h07);
    rc(CTL_OFF, CTL_WMASK);
    wr(CTL_OFF, 8'h02);
    step(2);
    check({rts0, dtr0, lb0}, 8'h02);
    wr(PORT_STRIDE + CTL_OFF, 8'h02);
    step(2);
    check({rts1, dtr1}, 8'h01);
    wr(PORT_STRIDE + CTL_OFF, 8'h13);
    step(2);
    check({rts1, dtr1, lb1}, 8'h07);
    wr(4'hB, 8'hFF);
    rc(4'hB, 8'h00);
    // Lines drop one at a time, levels accumulate
    for (int p = 0; p < PORT_N; p++)
    begin
      lv = '0;
      a = p ? PORT_STRIDE + STS_OFF : STS_OFF;
      for (int i = 0; i < LINE_N; i++)
      begin
        @(posedge clk_i);
        if (p == 0)
          want0[i] <= 1'b0;
        else
          want1[i] <= 1'b0;
        lv[i] = 1'b1;
        step(6);
        rc(a, {lv, 4'(1 << i)});
        rc(a, {lv, DELTA_NONE});
      end
    end
    wr(IER_OFF, 8'h08);
    wr(INT_MASK_OFF, 8'h01);
    rc(INT_STAT_OFF, 8'h03);
    @(posedge clk_i);
    want0 <= LINE_IDLE;
    step(6);
    check({irq0, irq}, 8'h03);
    rc(INT_STAT_OFF, 8'h01);
    rc(STS_OFF, 8'h0F);
    step(1);
    check({irq0, irq}, 8'h00);
    wr(INT_MASK_OFF, 8'h00);
    @(posedge clk_i);
    want1 <= LINE_IDLE;
    step(6);
    check({irq1, irq}, 8'h00);
    rc(INT_STAT_OFF, 8'h02);
    // Enabling late still reports the pending change
    wr(PORT_STRIDE + IER_OFF, 8'h08);
    step(2);
    check(irq1, 8'h01);
    for (int m = 0; m < 2; m++)
    begin
      wr(IR_CTRL_OFF, 8'(m));
      for (int k = 0; k < 4; k++)
      begin
        @(posedge clk_i);
        {tx_s, tx_ir} <= 2'(k);
        want0.cts <= k[0];
        step(2);
        check(ser, m ? tx_ir : tx_s);
      end
    end
    summarize();
  end

  initial
  begin
    #(CLK_PERIOD_NS * 5000);
    fail_count++;
    summarize();
  end
endmodule
`default_nettype wire
